// *** fsc_consts.svh ***
// constants of the flash command sequencer: offsets, fields, timing
`ifndef FSC_CONSTS_SVH
`define FSC_CONSTS_SVH
`define FSC_REG_CTRL 8'h00
`define FSC_REG_ADDR 8'h04
`define FSC_REG_STAT 8'h08
`define FSC_REG_DATA 8'h0c
`define FSC_CTRL_GO 31
`define FSC_CTRL_WP 8
`define FSC_CTRL_RESET 32'h0000_0000
`define FSC_STAT_BUSY 0
`define FSC_STAT_EFAIL 1
`define FSC_STAT_REFUSED 2
`define FSC_STAT_PIN 3
`define FSC_SR_READY 7
`define FSC_SR_ERASE 5
`define FSC_CLK_NS 25
`define FSC_STROBE_NS 75
`define FSC_STROBE_CYC ((`FSC_STROBE_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`define FSC_GAP_CYC 1
`endif

// *** fsc_cyc_if.sv ***
// one flash bus cycle request and its answer
`timescale 1ns/1ps
`default_nettype none
interface fsc_cyc_if #(parameter int AW = 22, parameter int DW = 16);
  logic start; // one-cycle request
  logic wr; // 1 write cycle, 0 read cycle
  logic [AW-1:0] addr; // flash address
  logic [DW-1:0] wdata; // write data
  logic done; // one-cycle end of cycle
  logic [DW-1:0] rdata; // data sampled on a read
  modport seq (output start, output wr, output addr, output wdata,
               input done, input rdata);
  modport eng (input start, input wr, input addr, input wdata,
               output done, output rdata);
endinterface : fsc_cyc_if
`default_nettype wire

// *** fsc_cycle.sv ***
// strobe engine: one flash write or read cycle per request
`timescale 1ns/1ps
`default_nettype none
`include "fsc_consts.svh"
module fsc_cycle #(
  parameter int AW = 22,
  parameter int DW = 16
) (
  input wire logic i_clk, // 40 MHz clock
  input wire logic i_reset_n, // async reset, active low
  fsc_cyc_if.eng cyc, // request side
  input wire logic [DW-1:0] i_dq, // data pins in
  output logic [DW-1:0] o_dq, // data pins out
  output logic o_dq_oe_n, // low while driving data
  output logic [AW-1:0] o_addr, // address pins
  output logic o_ce_a_n, // chip select a
  output logic o_ce_b_n, // chip select b
  output logic o_oe_n, // output enable
  output logic o_we_n // write enable
);
  localparam logic [3:0] STROBE = 4'(`FSC_STROBE_CYC);
  localparam logic [3:0] GAP = 4'(`FSC_GAP_CYC);
  logic [1:0] ph_q, ph_d; // 0 idle, 1 strobe, 2 gap
  logic [3:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic ce_q, ce_d, oe_q, oe_d, we_q, we_d, drv_q, drv_d, done_q, done_d;
  logic [DW-1:0] dq_q, dq_d, rd_q, rd_d;
  logic [AW-1:0] addr_q, addr_d;

  // next values: both selects fall with the strobe, so the last falling edge is ours
  always_comb begin
    ph_d = ph_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    ce_d = ce_q;
    oe_d = oe_q;
    we_d = we_q;
    drv_d = drv_q;
    dq_d = dq_q;
    rd_d = rd_q;
    addr_d = addr_q;
    done_d = 1'b0;
    case (ph_q)
      2'd0: begin
        if (cyc.start) begin
          ph_d = 2'd1;
          cnt_d = STROBE;
          wr_d = cyc.wr;
          addr_d = cyc.addr;
          dq_d = cyc.wdata;
          ce_d = 1'b0;
          we_d = ~cyc.wr;
          oe_d = cyc.wr;
          drv_d = ~cyc.wr; // drive only on writes
        end
      end
      2'd1: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          ph_d = 2'd2;
          cnt_d = GAP;
          ce_d = 1'b1; // strobes rise, refreshing the status latch next time
          oe_d = 1'b1;
          we_d = 1'b1;
          if (!wr_q) begin
            rd_d = i_dq;
          end
        end
      end
      2'd2: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          ph_d = 2'd0;
          drv_d = 1'b1; // data held through the gap, then released
          done_d = 1'b1;
        end
      end
      default: begin
        ph_d = 2'd0;
      end
    endcase
  end

  // registers of the strobe engine
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ph_q <= 2'd0;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      ce_q <= 1'b1;
      oe_q <= 1'b1;
      we_q <= 1'b1;
      drv_q <= 1'b1;
      dq_q <= '0;
      rd_q <= '0;
      addr_q <= '0;
      done_q <= 1'b0;
    end else begin
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      ce_q <= ce_d;
      oe_q <= oe_d;
      we_q <= we_d;
      drv_q <= drv_d;
      dq_q <= dq_d;
      rd_q <= rd_d;
      addr_q <= addr_d;
      done_q <= done_d;
    end
  end

  assign o_ce_a_n = ce_q;
  assign o_ce_b_n = ce_q;
  assign o_oe_n = oe_q;
  assign o_we_n = we_q;
  assign o_dq_oe_n = drv_q;
  assign o_dq = dq_q;
  assign o_addr = addr_q;
  assign cyc.done = done_q;
  assign cyc.rdata = rd_q;

  property p_oe_toggle;
    @(posedge i_clk) disable iff (!i_reset_n)
    $fell(o_oe_n) |-> ##(`FSC_STROBE_CYC) o_oe_n ##1 cyc.done;
  endproperty
  a_oe_toggle: assert property (p_oe_toggle) else $error("output enable not toggled");

  property p_we_drives;
    @(posedge i_clk) disable iff (!i_reset_n)
    !o_we_n |-> (!o_dq_oe_n && !o_ce_a_n && o_oe_n);
  endproperty
  a_we_drives: assert property (p_we_drives) else $error("write without data drive");
endmodule : fsc_cycle
`default_nettype wire

// *** fsc_flash_model.sv ***
// behavioural flash device answering the sequencer's strobes
`timescale 1ns/1ps
`default_nettype none
module fsc_flash_model #(
  parameter logic [7:0] MFR_CODE = 8'h3c, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h5e, // arbitrary value
  parameter int BUSY_READS = 3 // status reads that still show busy after an erase
) (
  input wire logic [21:0] i_addr, // address pins
  input wire logic [15:0] i_dq_host, // data driven by the host
  input wire logic i_dq_oe_n, // low while the host drives data
  input wire logic i_ce_a_n, // chip select a
  input wire logic i_ce_b_n, // chip select b
  input wire logic i_oe_n, // output enable
  input wire logic i_we_n, // write enable
  input wire logic i_wp, // write protect level
  input wire logic i_supply_ok, // programming supply above lockout
  input wire logic i_buf_free, // a write buffer is free
  input wire logic [63:0] i_lock, // lock bit of each block
  output logic [15:0] o_dq, // level seen on the data wires
  output logic o_ready // ready/busy level of the status pin
);
  localparam logic [7:0] C_ARR = 8'h11;
  localparam logic [7:0] C_ID = 8'h12;
  localparam logic [7:0] C_ST = 8'h13;
  localparam logic [7:0] C_BUF = 8'h14;
  localparam logic [7:0] C_CLR = 8'h15;
  localparam logic [7:0] C_ERS = 8'h16;
  localparam logic [7:0] C_OK = 8'h17;
  logic [6:0] err = 7'h00; // sticky error bits, clear at power-up
  logic [1:0] mode = 2'h0; // 0 array, 1 identifier, 2 status, 3 extended status
  logic pend = 1'b0; // erase setup seen, confirm due
  int busy = 0; // status reads left before the engine is ready
  logic [63:0] erased = '0; // blocks erased so far
  logic [63:0] failed = '0; // last erase of the block failed
  logic [15:0] lat = 16'h0000; // value latched for the current read
  logic [15:0] last = 16'h0000; // last value driven, inverted once released
  wire wr_on = !i_we_n && !i_ce_a_n && !i_ce_b_n;
  wire rd_on = !i_oe_n && !i_ce_a_n && !i_ce_b_n;
  wire [5:0] blk = i_addr[21:16];
  assign o_ready = (busy == 0);
  // released wires show the inverse of the last value so stale data never passes
  assign o_dq = !i_dq_oe_n ? i_dq_host : (rd_on ? lat : ~last);
  // commands are taken as write enable rises
  always @(negedge wr_on) begin
    if (pend) begin
      pend = 1'b0;
      mode = 2'h2;
      if (i_dq_host[7:0] != C_OK) err = err | 7'h30;
      else if (!i_supply_ok) begin
        err = err | 7'h28;
        failed[blk] = 1'b1;
      end else if (i_lock[blk] && !i_wp) begin
        err = err | 7'h22;
        failed[blk] = 1'b1;
      end else begin // only the addressed block is erased
        erased[blk] = 1'b1;
        failed[blk] = 1'b0;
        busy = BUSY_READS;
      end
    end else begin
      case (i_dq_host[7:0])
        C_ARR: mode = 2'h0;
        C_ID: mode = 2'h1;
        C_ST: mode = 2'h2;
        C_BUF: mode = 2'h3;
        C_CLR: err = 7'h00; // no suspend is modelled, so clearing always acts
        C_ERS: pend = 1'b1;
        default: ;
      endcase
    end
  end
  // read value latched on the last falling strobe
  always @(posedge rd_on) begin
    case (mode)
      2'h0: lat = erased[blk] ? 16'hffff : i_addr[15:0] ^ 16'ha5c3;
      2'h1: begin // address bit 0 is ignored
        if (i_addr[15:1] == 15'h0000) lat = {8'h00, MFR_CODE};
        else if (i_addr[15:1] == 15'h0001) lat = {8'h00, DEV_CODE};
        else if (i_addr[15:1] == 15'h0002) lat = {14'h0000, failed[blk], i_lock[blk]};
        else lat = 16'h0000;
      end
      2'h2: begin
        if (busy > 0) begin // only the ready bit means anything yet
          lat = {9'h000, 7'($urandom)};
          busy = busy - 1;
        end else lat = {8'h00, 1'b1, err};
      end
      default: lat = {8'h00, i_buf_free, 7'h00};
    endcase
    last = lat;
  end
endmodule : fsc_flash_model
`default_nettype wire

// *** fsc_host.sv ***
// host sequencer: apb registers in, flash command cycles out
// Operation
// - identifier command, then reads return identifier codes
// - status latched on last strobe fall; toggle
// - buffer setup command, reads give extended status
// - erase is setup write then confirm write
// - poll ready bit, toggling strobes between polls
// - check erase error, clear before corrective action
`timescale 1ns/1ps
`default_nettype none
`include "fsc_consts.svh"
module fsc_host #(
  parameter int AW = 22,
  parameter int DW = 16,
  parameter logic [7:0] CMD_ARRAY = 8'h11, // codes are settable per part
  parameter logic [7:0] CMD_ID = 8'h12,
  parameter logic [7:0] CMD_STAT = 8'h13,
  parameter logic [7:0] CMD_BUF = 8'h14,
  parameter logic [7:0] CMD_CLEAR = 8'h15,
  parameter logic [7:0] CMD_ERASE = 8'h16,
  parameter logic [7:0] CMD_CONFIRM = 8'h17
) (
  input wire logic i_clk, // 40 MHz clock
  input wire logic i_reset_n, // async reset, active low
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb access phase
  input wire logic i_pwrite, // apb direction
  input wire logic [7:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error on unmapped address
  input wire logic [DW-1:0] i_dq, // flash data in
  output logic [DW-1:0] o_dq, // flash data out
  output logic o_dq_oe_n, // low while driving data
  output logic [AW-1:0] o_addr, // flash address
  output logic o_ce_a_n, // chip select a
  output logic o_ce_b_n, // chip select b
  output logic o_oe_n, // output enable
  output logic o_we_n, // write enable
  output logic o_write_protect, // write protect pin level
  input wire logic i_status_pin // ready/busy level from the device
);
  fsc_cyc_if #(.AW(AW), .DW(DW)) cyc ();
  fsc_pkg::fsc_state_t st_q, st_d;
  fsc_pkg::fsc_op_t op_q, op_d;
  logic [31:0] ctrl_q, ctrl_d; // op and write protect level
  logic [AW-1:0] addr_q, addr_d; // target address
  logic [DW-1:0] data_q, data_d; // last data read from the flash
  logic efail_q, efail_d; // erase ended with an error
  logic refused_q, refused_d; // a request was refused
  logic start_q, start_d, wr_q, wr_d;
  logic [DW-1:0] wdata_q, wdata_d;
  logic [AW-1:0] caddr_q, caddr_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic acc, wacc, go;

  assign acc = i_psel && i_penable && !pready_q; // first access cycle, answer computed
  // writes land only at the edge where the master sees pready high, never earlier
  assign wacc = i_psel && i_penable && pready_q && i_pwrite;
  assign go = wacc && (i_paddr == `FSC_REG_CTRL) && i_pwdata[`FSC_CTRL_GO];

  // first command word of each operation
  function automatic logic [7:0] first_cmd(input fsc_pkg::fsc_op_t op);
    case (op)
      fsc_pkg::OP_ID: first_cmd = CMD_ID;
      fsc_pkg::OP_STAT: first_cmd = CMD_STAT;
      fsc_pkg::OP_XSTAT: first_cmd = CMD_BUF;
      fsc_pkg::OP_CLEAR: first_cmd = CMD_CLEAR;
      fsc_pkg::OP_ERASE: first_cmd = CMD_ERASE;
      default: first_cmd = CMD_ARRAY;
    endcase
  endfunction : first_cmd

  // sequencer and register next values
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    ctrl_d = ctrl_q;
    addr_d = addr_q;
    data_d = data_q;
    efail_d = efail_q;
    refused_d = refused_q;
    start_d = 1'b0;
    wr_d = wr_q;
    wdata_d = wdata_q;
    caddr_d = caddr_q;
    if (wacc && (i_paddr == `FSC_REG_ADDR)) begin
      addr_d = i_pwdata[AW-1:0];
    end
    if (wacc && (i_paddr == `FSC_REG_CTRL)) begin
      ctrl_d = {1'b0, i_pwdata[30:0]}; // go reads back as zero
    end
    case (st_q)
      fsc_pkg::ST_IDLE: begin
        if (go) begin
          op_d = fsc_pkg::fsc_op_t'(i_pwdata[2:0]);
          if (fsc_pkg::fsc_op_t'(i_pwdata[2:0]) == fsc_pkg::OP_ERASE && efail_q) begin
            refused_d = 1'b1; // no new erase before status is cleared
          end else begin
            refused_d = 1'b0;
            st_d = fsc_pkg::ST_W1;
            start_d = 1'b1;
            wr_d = 1'b1;
            wdata_d = DW'(first_cmd(fsc_pkg::fsc_op_t'(i_pwdata[2:0])));
            caddr_d = addr_q; // block address goes with setup
          end
        end
      end
      fsc_pkg::ST_W1: begin
        if (cyc.done) begin
          start_d = 1'b1;
          case (op_q)
            fsc_pkg::OP_CLEAR: begin
              start_d = 1'b0;
              efail_d = 1'b0; // host clears its copy with the device
              st_d = fsc_pkg::ST_IDLE;
            end
            fsc_pkg::OP_ERASE: begin
              st_d = fsc_pkg::ST_W2;
              wdata_d = DW'(CMD_CONFIRM); // confirm in the same block
            end
            default: begin
              st_d = fsc_pkg::ST_RD; // mode holds until the next command
              wr_d = 1'b0;
            end
          endcase
        end
      end
      fsc_pkg::ST_W2: begin
        if (cyc.done) begin
          st_d = fsc_pkg::ST_POLL; // device now answers with status
          start_d = 1'b1;
          wr_d = 1'b0;
        end
      end
      fsc_pkg::ST_RD: begin
        if (cyc.done) begin
          data_d = cyc.rdata;
          st_d = fsc_pkg::ST_IDLE;
        end
      end
      fsc_pkg::ST_POLL: begin
        if (cyc.done) begin
          data_d = cyc.rdata;
          if (cyc.rdata[`FSC_SR_READY]) begin
            st_d = fsc_pkg::ST_FIN; // other bits only trusted now
          end else begin
            start_d = 1'b1; // fresh read cycle re-latches status
          end
        end
      end
      fsc_pkg::ST_FIN: begin
        efail_d = data_q[`FSC_SR_ERASE];
        st_d = fsc_pkg::ST_IDLE;
      end
      default: begin
        st_d = fsc_pkg::ST_IDLE;
      end
    endcase
  end

  // apb answer: one wait state so read data leaves a flop
  always_comb begin
    pready_d = acc;
    pslverr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    if (acc) begin
      case (i_paddr)
        `FSC_REG_CTRL: prdata_d = ctrl_q;
        `FSC_REG_ADDR: prdata_d = 32'(addr_q);
        `FSC_REG_STAT: begin
          prdata_d[`FSC_STAT_BUSY] = (st_q != fsc_pkg::ST_IDLE);
          prdata_d[`FSC_STAT_EFAIL] = efail_q;
          prdata_d[`FSC_STAT_REFUSED] = refused_q;
          prdata_d[`FSC_STAT_PIN] = i_status_pin;
        end
        `FSC_REG_DATA: prdata_d = 32'(data_q);
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  // registers of the sequencer and bus slave
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= fsc_pkg::ST_IDLE;
      op_q <= fsc_pkg::OP_ARRAY;
      ctrl_q <= `FSC_CTRL_RESET;
      addr_q <= '0;
      data_q <= '0;
      efail_q <= 1'b0;
      refused_q <= 1'b0;
      start_q <= 1'b0;
      wr_q <= 1'b0;
      wdata_q <= '0;
      caddr_q <= '0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      ctrl_q <= ctrl_d;
      addr_q <= addr_d;
      data_q <= data_d;
      efail_q <= efail_d;
      refused_q <= refused_d;
      start_q <= start_d;
      wr_q <= wr_d;
      wdata_q <= wdata_d;
      caddr_q <= caddr_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign cyc.start = start_q;
  assign cyc.wr = wr_q;
  assign cyc.wdata = wdata_q;
  assign cyc.addr = caddr_q;
  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_write_protect = ctrl_q[`FSC_CTRL_WP]; // high lets locked blocks erase

  fsc_cycle #(.AW(AW), .DW(DW)) u_cycle (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .cyc(cyc),
    .i_dq(i_dq),
    .o_dq(o_dq),
    .o_dq_oe_n(o_dq_oe_n),
    .o_addr(o_addr),
    .o_ce_a_n(o_ce_a_n),
    .o_ce_b_n(o_ce_b_n),
    .o_oe_n(o_oe_n),
    .o_we_n(o_we_n)
  );

  sequence s_setup_done;
    st_q == fsc_pkg::ST_W1 && op_q == fsc_pkg::OP_ERASE && cyc.done;
  endsequence
  property p_erase_two_writes;
    @(posedge i_clk) disable iff (!i_reset_n)
    s_setup_done |=> cyc.start && cyc.wr && cyc.wdata == DW'(CMD_CONFIRM);
  endproperty
  a_erase_two_writes: assert property (p_erase_two_writes) else $error("no confirm");
  property p_id_read;
    @(posedge i_clk) disable iff (!i_reset_n)
    st_q == fsc_pkg::ST_W1 && op_q == fsc_pkg::OP_ID && cyc.done
      |=> st_q == fsc_pkg::ST_RD && cyc.start && !cyc.wr;
  endproperty
  a_id_read: assert property (p_id_read) else $error("identifier read missing");
  property p_poll_again;
    @(posedge i_clk) disable iff (!i_reset_n)
    st_q == fsc_pkg::ST_POLL && cyc.done && !cyc.rdata[`FSC_SR_READY] |=> cyc.start;
  endproperty
  a_poll_again: assert property (p_poll_again) else $error("poll stopped early");
  property p_poll_end;
    @(posedge i_clk) disable iff (!i_reset_n)
    st_q == fsc_pkg::ST_POLL && cyc.done && cyc.rdata[`FSC_SR_READY]
      |=> st_q == fsc_pkg::ST_FIN ##1 st_q == fsc_pkg::ST_IDLE;
  endproperty
  a_poll_end: assert property (p_poll_end) else $error("poll did not finish");
  property p_refuse;
    @(posedge i_clk) disable iff (!i_reset_n)
    go && efail_q && i_pwdata[2:0] == 3'h5 && st_q == fsc_pkg::ST_IDLE
      |=> st_q == fsc_pkg::ST_IDLE && refused_q;
  endproperty
  a_refuse: assert property (p_refuse) else $error("erase taken with error set");
  property p_xstat_cmd;
    @(posedge i_clk) disable iff (!i_reset_n)
    $rose(st_q == fsc_pkg::ST_W1) && op_q == fsc_pkg::OP_XSTAT |-> cyc.wdata == DW'(CMD_BUF);
  endproperty
  a_xstat_cmd: assert property (p_xstat_cmd) else $error("buffer setup not sent");
  property p_apb_wait;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_psel && i_penable && !o_pready |=> o_pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer late");
endmodule : fsc_host
`default_nettype wire

// *** fsc_pkg.sv ***
// types of the flash command sequencer
package fsc_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_W1 = 6'h02,
    ST_W2 = 6'h04,
    ST_RD = 6'h08,
    ST_POLL = 6'h10,
    ST_FIN = 6'h20
  } fsc_state_t;
  typedef enum logic [2:0] {
    OP_ARRAY = 3'h0,
    OP_ID = 3'h1,
    OP_STAT = 3'h2,
    OP_XSTAT = 3'h3,
    OP_CLEAR = 3'h4,
    OP_ERASE = 3'h5
  } fsc_op_t;
endpackage : fsc_pkg

// *** test_fsc_host.sv ***
// self-checking bench of the flash command sequencer against a device model
`timescale 1ns/1ps
`default_nettype none
`include "fsc_consts.svh"
module test_fsc_host;
  logic i_clk = 1'b0; // 40 MHz clock
  logic i_reset_n = 1'b0; // held low for the first two cycles
  logic i_psel = 1'b0; // apb request
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, o_dq_oe_n, o_ce_a_n, o_ce_b_n, o_oe_n, o_we_n, o_write_protect;
  logic [15:0] i_dq, o_dq;
  logic [21:0] o_addr;
  logic i_status_pin;
  logic supply_ok = 1'b1; // programming supply level
  logic buf_free = 1'b0; // write buffer availability
  logic [63:0] lock_bits = '0; // lock bit of each block
  int fails = 0;
  int checks_done = 0;
  logic [6:0] err_e = 7'h00; // expected sticky error bits
  logic [63:0] erased_e = '0; // expected erased blocks
  logic [63:0] failed_e = '0; // expected last-erase failures
  logic [31:0] rd, st; // last apb read data and last busy-free status
  logic perr; // last apb error flag
  logic pin_lo; // status pin seen busy while an operation ran
  always #12.5 i_clk = ~i_clk;
  fsc_host fsc_host_i (.i_clk, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_dq, .o_dq, .o_dq_oe_n, .o_addr,
    .o_ce_a_n, .o_ce_b_n, .o_oe_n, .o_we_n, .o_write_protect, .i_status_pin);
  fsc_flash_model fsc_flash_model_i (.i_addr(o_addr), .i_dq_host(o_dq), .i_dq_oe_n(o_dq_oe_n),
    .i_ce_a_n(o_ce_a_n), .i_ce_b_n(o_ce_b_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
    .i_wp(o_write_protect), .i_supply_ok(supply_ok), .i_buf_free(buf_free),
    .i_lock(lock_bits), .o_dq(i_dq), .o_ready(i_status_pin));
  // verdict and end of run, also reached by any exhausted wait
  task automatic results();
    $display("comparisons %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (o_pready === 1'b1) break;
    end
    if (n == 50) begin
      fails++;
      results();
    end
    rd = o_prdata;
    perr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  // start one operation, wait for busy to drop, then fetch the flash data
  task automatic op(input logic [2:0] code, input logic [21:0] a, input logic wp);
    int n;
    apb(1'b1, `FSC_REG_ADDR, {10'h000, a});
    apb(1'b1, `FSC_REG_CTRL, {1'b1, 22'h000000, wp, 5'h00, code});
    pin_lo = 1'b0;
    for (n = 0; n < 400; n++) begin
      apb(1'b0, `FSC_REG_STAT, 32'h0);
      if (rd[`FSC_STAT_PIN] === 1'b0) pin_lo = 1'b1;
      if (rd[`FSC_STAT_BUSY] === 1'b0) break;
    end
    if (n == 400) begin
      fails++;
      results();
    end
    st = rd;
    apb(1'b0, `FSC_REG_DATA, 32'h0);
  endtask : op
  function automatic logic [15:0] arr_e(input logic [21:0] a);
    return erased_e[a[21:16]] ? 16'hffff : a[15:0] ^ 16'ha5c3;
  endfunction : arr_e
  // erase through the sequencer, expectation from supply, lock and protect
  task automatic erase(input logic [21:0] a, input logic wp);
    logic fl;
    fl = !supply_ok || (lock_bits[a[21:16]] && !wp);
    op(3'h5, a, wp);
    if (!supply_ok) err_e = err_e | 7'h28;
    else if (fl) err_e = err_e | 7'h22;
    else erased_e[a[21:16]] = 1'b1;
    failed_e[a[21:16]] = fl;
    chk("erase fail flag", 32'(st[`FSC_STAT_EFAIL]), 32'(fl));
    chk("final erase status", 32'(rd[7:0]), {24'h0, 1'b1, err_e});
    chk("status pin ready", 32'(st[`FSC_STAT_PIN]), 32'h1);
    chk("status pin busy seen", 32'(pin_lo), 32'(!fl));
  endtask : erase
  initial begin
    logic [21:0] a;
    void'($urandom(70604));
    lock_bits = {$urandom, $urandom};
    lock_bits[5] = 1'b1;
    lock_bits[9] = 1'b0;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    chk("idle pins", 32'({o_ce_a_n, o_ce_b_n, o_oe_n, o_we_n, o_dq_oe_n, o_write_protect}),
      32'h3e);
    apb(1'b0, `FSC_REG_CTRL, 32'h0);
    chk("ctrl reset", rd, `FSC_CTRL_RESET);
    chk("mapped no error", 32'(perr), 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped error", 32'(perr), 32'h1);
    op(3'h2, 22'h0, 1'b0);
    chk("status after reset", 32'(rd[7:0]), 32'h80);
    op(3'h1, 22'h0, 1'b0);
    chk("manufacturer code", 32'(rd[15:0]), 32'h3c);
    op(3'h1, 22'h1, 1'b0);
    chk("manufacturer code a0 set", 32'(rd[15:0]), 32'h3c);
    op(3'h1, 22'h2, 1'b0);
    chk("device code", 32'(rd[15:0]), 32'h5e);
    supply_ok = 1'b0;
    for (int i = 0; i < 4; i++) begin
      a = 22'($urandom);
      op(3'h0, a, 1'b0);
      chk("array read low supply", 32'(rd[15:0]), 32'(arr_e(a)));
      op(3'h1, {a[21:16], 16'h0004}, 1'b0);
      chk("block lock code", 32'(rd[15:0]), 32'(lock_bits[a[21:16]]));
    end
    erase(22'h070010, 1'b0);
    op(3'h0, 22'h070010, 1'b0);
    chk("block kept", 32'(rd[15:0]), 32'(arr_e(22'h070010)));
    op(3'h2, 22'h0, 1'b0);
    chk("errors sticky", 32'(rd[7:0]), {24'h0, 1'b1, err_e});
    op(3'h5, 22'h090000, 1'b0);
    chk("erase refused", 32'(st[`FSC_STAT_REFUSED]), 32'h1);
    op(3'h4, 22'h0, 1'b0); // clear before the next attempt
    err_e = 7'h00;
    chk("fail flag cleared", 32'(st[`FSC_STAT_EFAIL]), 32'h0);
    op(3'h2, 22'h0, 1'b0);
    chk("cleared at low supply", 32'(rd[7:0]), 32'h80);
    supply_ok = 1'b1;
    erase(22'h050100, 1'b0);
    op(3'h1, 22'h050004, 1'b0);
    chk("lock and fail bits", 32'(rd[15:0]), 32'h3);
    op(3'h4, 22'h0, 1'b0);
    err_e = 7'h00;
    erase(22'h050100, 1'b1);
    a = {6'd9, 16'($urandom)};
    erase(a, 1'b0);
    op(3'h0, a ^ 22'h00_0f0f, 1'b0);
    chk("erased block", 32'(rd[15:0]), 32'hffff);
    op(3'h0, 22'h0a0000 | a[15:0], 1'b0);
    chk("neighbour kept", 32'(rd[15:0]), 32'(arr_e(22'h0a0000 | a[15:0])));
    for (int i = 0; i < 2; i++) begin
      buf_free = i[0];
      op(3'h3, a, 1'b0);
      chk("extended status", 32'(rd[7:0]), {24'h0, buf_free, 7'h00});
    end
    results();
  end
endmodule : test_fsc_host
`default_nettype wire
